/* File: rtl/gppa_ahb_slave.sv */
// AHB-Lite slave front end with zero wait states
`timescale 1ns/1ps
module gppa_ahb_slave (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Register side
   input wire logic [31:0] rd_word,
   output gppa_pkg::gppa_reg_wr_type reg_wr
);
   logic take;
   logic wr_pend_r;
   logic [gppa_pkg::OFS_W-1:0] wr_addr_r;

   assign take = hsel && htrans[1] && hready;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else begin
         // Only whole-word writes land
         wr_pend_r <= take && hwrite && (hsize == gppa_pkg::SIZE_WORD);
         if (take) begin
            wr_addr_r <= haddr[gppa_pkg::OFS_W-1:0];
         end
      end
   end

   // Read word is caught at the address edge, so it stands in the data phase
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hrdata <= 32'h0;
      end else if (take && !hwrite) begin
         hrdata <= rd_word;
      end
   end

   always_ff @(posedge ref_clk) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
   end

   always_comb begin
      reg_wr.en = wr_pend_r;
      reg_wr.addr = wr_addr_r;
      reg_wr.data = hwdata;
   end
endmodule // gppa_ahb_slave

/* File: rtl/gppa_pkg.sv */
// Package: constants, carrier types and decoders of the port A block
package gppa_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int PORT_W = 8;
   localparam int CFG_W = 4;
   localparam int AN_W = 6;
   localparam int OFS_W = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_PIN_LEVELS = 8'h00;
   localparam logic [7:0] OFS_OUT_LATCH = 8'h04;
   localparam logic [7:0] OFS_DIRECTION = 8'h08;
   localparam logic [7:0] OFS_CONV_CFG = 8'h0c;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and field layout
   localparam logic [7:0] LAT_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hff;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] CFG_WMASK = 8'h3f;
   localparam int CFG_VREF_LSB = 4;
   localparam int PIN_OD = 4;
   localparam int PIN_CYCLE_CLOCK_OUT = 6;
   localparam logic [2:0] SIZE_WORD = 3'h2;

   // Cycle clock is the oscillator divided by four
   localparam int CYCLE_DIV = 4;
   localparam int CYC_W = $clog2(CYCLE_DIV);

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [3:0] {
      lp_crystal_mode,
      xt_crystal_mode,
      hs_crystal_mode,
      hs_pll_mode,
      resistor_capacitor_osc_mode,
      rc_osc_with_io_mode,
      ext_clock_mode,
      ext_clock_with_io_mode,
      internal_osc_dual_io_mode,
      internal_osc_clock_out_mode
   } gppa_osc_mode_type;

   typedef struct packed {
      logic [PORT_W-1:0] out;
      logic [PORT_W-1:0] oe;
   } gppa_pin_drive_type;

   typedef struct packed {
      logic en;
      logic [OFS_W-1:0] addr;
      logic [31:0] data;
   } gppa_reg_wr_type;

   ////////////////////////////////////////////////////////////////////////////
   // Decoders
   // Channel k (0-3) is analog while the select field is below 15-k; channel 5 while below 11
   function automatic logic [AN_W-1:0] analog_pins(input logic [CFG_W-1:0] sel);
      logic [4:0] chan;
      chan = '0;
      for (int k = 0; k < 5; k++) begin
         chan[k] = (sel < 4'(15 - k));
      end
      return {chan[4], 1'b0, chan[3:0]};
   endfunction

   function automatic logic [PORT_W-1:0] port_avail(input gppa_osc_mode_type m);
      logic six;
      logic seven;
      six = (m == rc_osc_with_io_mode) || (m == internal_osc_dual_io_mode) ||
            (m == ext_clock_with_io_mode);
      seven = (m == internal_osc_dual_io_mode) || (m == internal_osc_clock_out_mode);
      return {seven, six, 6'h3f};
   endfunction

   function automatic logic clkout_on(input gppa_osc_mode_type m);
      logic [PORT_W-1:0] freed;
      freed = port_avail(m);
      return !freed[PIN_CYCLE_CLOCK_OUT] && (m != resistor_capacitor_osc_mode) &&
             (m != internal_osc_clock_out_mode) && (m != ext_clock_mode);
   endfunction

endpackage

/* File: rtl/gppa_port_a.sv */
// Port A: eight-bit general-purpose port with shared analog and clock pins
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module gppa_port_a (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Oscillator configuration
   input gppa_pkg::gppa_osc_mode_type osc_mode,
   // Pins
   input wire logic [gppa_pkg::PORT_W-1:0] pin_in,
   output gppa_pkg::gppa_pin_drive_type pin_drive,
   // Peripheral side
   output logic timer_zero_ext_clock,
   output logic [gppa_pkg::AN_W-1:0] analog_pin_enable,
   output logic [1:0] vref_config
);

   /////////////////////////////////////////////////////////////////////////////
   // Declarations
   localparam int W = gppa_pkg::PORT_W;

   gppa_pkg::gppa_reg_wr_type reg_wr;
   gppa_pkg::gppa_pin_drive_type drive_nxt;
   logic [W-1:0] lat_r;
   logic [W-1:0] lat_nxt;
   logic [W-1:0] dir_r;
   logic [W-1:0] dir_nxt;
   logic [7:0] cfg_r;
   logic [7:0] cfg_nxt;
   logic [W-1:0] pin_sync;
   logic [W-1:0] avail;
   logic [W-1:0] an_pins;
   logic [W-1:0] an_pins_nxt;
   logic [gppa_pkg::CYC_W-1:0] cyc_cnt_r;
   logic [31:0] rd_word;
   logic cycle_clock_out_on;
   logic rd_take;
   logic [gppa_pkg::OFS_W-1:0] rd_ofs;

   /////////////////////////////////////////////////////////////////////////////
   // Bus front end and synchroniser
   gppa_ahb_slave u_bus (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .rd_word(rd_word),
      .reg_wr(reg_wr)
   );

   gppa_sync #(
      .WIDTH(W)
   ) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .d(pin_in),
      .q_r(pin_sync)
   );

   /////////////////////////////////////////////////////////////////////////////
   // Pin ownership
   assign avail = gppa_pkg::port_avail(osc_mode);
   assign cycle_clock_out_on = gppa_pkg::clkout_on(osc_mode);
   assign an_pins = {2'b00, gppa_pkg::analog_pins(cfg_r[gppa_pkg::CFG_W-1:0])};
   assign an_pins_nxt = {2'b00, gppa_pkg::analog_pins(cfg_nxt[gppa_pkg::CFG_W-1:0])};
   assign rd_take = hsel && htrans[1] && hready && !hwrite;
   assign rd_ofs = haddr[gppa_pkg::OFS_W-1:0];

   /////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_comb begin
      lat_nxt = lat_r;
      dir_nxt = dir_r;
      cfg_nxt = cfg_r;
      if (reg_wr.en) begin
         case (reg_wr.addr)
            gppa_pkg::OFS_PIN_LEVELS: begin
               lat_nxt = reg_wr.data[W-1:0];
            end
            gppa_pkg::OFS_OUT_LATCH: begin
               lat_nxt = reg_wr.data[W-1:0];
            end
            gppa_pkg::OFS_DIRECTION: begin
               dir_nxt = reg_wr.data[W-1:0];
            end
            gppa_pkg::OFS_CONV_CFG: begin
               cfg_nxt = reg_wr.data[7:0] & gppa_pkg::CFG_WMASK;
            end
            default: begin
               lat_nxt = lat_r;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         lat_r <= gppa_pkg::LAT_RST;
      end else begin
         lat_r <= lat_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dir_r <= gppa_pkg::DIR_RST;
      end else begin
         dir_r <= dir_nxt;
      end
   end

   // Select field resets to all-analog, the safe state for mixed-signal pins
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cfg_r <= gppa_pkg::CFG_RST;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Register reads
   // Uses the next values so a read right behind a write sees it
   always_comb begin
      rd_word = 32'h0;
      case (rd_ofs)
         gppa_pkg::OFS_PIN_LEVELS: begin
            rd_word[W-1:0] = pin_sync & avail & ~an_pins_nxt;
         end
         gppa_pkg::OFS_OUT_LATCH: begin
            rd_word[W-1:0] = lat_nxt & avail;
         end
         gppa_pkg::OFS_DIRECTION: begin
            rd_word[W-1:0] = dir_nxt & avail;
         end
         gppa_pkg::OFS_CONV_CFG: begin
            rd_word[7:0] = cfg_nxt;
         end
         default: begin
            rd_word = 32'h0;
         end
      endcase
   end

   /////////////////////////////////////////////////////////////////////////////
   // Cycle clock for pin 6
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cyc_cnt_r <= '0;
      end else begin
         cyc_cnt_r <= cyc_cnt_r + 1'b1;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Pin drivers
   // Analog selection is deliberately absent here: it never gates the driver
   always_comb begin
      drive_nxt.oe = ~dir_r & avail;
      drive_nxt.out = lat_r & avail;
      // Open drain: drive low only while the latch holds zero
      drive_nxt.out[gppa_pkg::PIN_OD] = 1'b0;
      drive_nxt.oe[gppa_pkg::PIN_OD] = !dir_r[gppa_pkg::PIN_OD] && !lat_r[gppa_pkg::PIN_OD];
      if (cycle_clock_out_on) begin
         drive_nxt.oe[gppa_pkg::PIN_CYCLE_CLOCK_OUT] = 1'b1;
         drive_nxt.out[gppa_pkg::PIN_CYCLE_CLOCK_OUT] = cyc_cnt_r[gppa_pkg::CYC_W-1];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_drive <= '0;
      end else begin
         pin_drive <= drive_nxt;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Peripheral outputs
   // Timer input is taken whatever the direction bit says
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         timer_zero_ext_clock <= 1'b0;
      end else begin
         timer_zero_ext_clock <= pin_sync[gppa_pkg::PIN_OD];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         analog_pin_enable <= '0;
         vref_config <= 2'h0;
      end else begin
         analog_pin_enable <= an_pins[gppa_pkg::AN_W-1:0];
         vref_config <= cfg_r[gppa_pkg::CFG_VREF_LSB +: 2];
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_wr_levels;
      reg_wr.en && (reg_wr.addr == gppa_pkg::OFS_PIN_LEVELS);
   endsequence

   sequence s_rd_latch;
      rd_take && (rd_ofs == gppa_pkg::OFS_OUT_LATCH);
   endsequence

   sequence s_rd_levels;
      rd_take && (rd_ofs == gppa_pkg::OFS_PIN_LEVELS);
   endsequence

   sequence s_mode_steady;
      $stable(osc_mode) [*2];
   endsequence

   AST_DIR_INPUT_OFF:
      assert property (s_mode_steady |-> ((pin_drive.oe & $past(dir_r) & 8'h3f) == 8'h00))
      else $error("Pin driven while its direction bit selects input");

   AST_DIR_OUTPUT_DRIVES:
      assert property (!dir_r[0] |=> pin_drive.oe[0] && (pin_drive.out[0] == $past(lat_r[0])))
      else $error("Output pin does not drive its latch bit");

   AST_LEVELS_WRITE_LATCH:
      assert property (s_wr_levels |=> lat_r == $past(reg_wr.data[7:0]))
      else $error("Write to pin-level register missed the latch");

   AST_LATCH_READBACK:
      assert property ((s_rd_latch ##0 $stable(osc_mode)) |=> hrdata[7:0] == (lat_r & avail))
      else $error("Latch read does not return the latched value");

   AST_BITS_PER_PIN:
      assert property (s_mode_steady |-> pin_drive.out[5] == ($past(lat_r[5]) && avail[5]))
      else $error("Pin 5 output not tied to latch bit 5");

   AST_CLAIMED_READ_ZERO:
      assert property ((s_rd_levels ##0 !avail[7]) |=> hrdata[7] == 1'b0)
      else $error("Claimed pin 7 reads nonzero");

   AST_ANALOG_READ_ZERO:
      assert property ((s_rd_levels ##0 an_pins_nxt[0]) |=> hrdata[0] == 1'b0)
      else $error("Analog pin 0 returned a digital level");

   AST_RESET_STATE:
      assert property ($fell(sys_rst) |-> (an_pins == 8'h2f) && !an_pins[4])
      else $error("Pins 0-3 and 5 not analog after reset");

   AST_ANALOG_KEEPS_DRIVE:
      assert property ((an_pins[1] && !dir_r[1]) |=> pin_drive.oe[1])
      else $error("Analog selection blocked the output driver");

   AST_OPEN_DRAIN:
      assert property (pin_drive.oe[4] |-> !pin_drive.out[4])
      else $error("Pin 4 driven high");

   AST_TIMER_CLOCK:
      assert property (!$past(sys_rst, 3) |-> timer_zero_ext_clock == $past(pin_in[4], 3))
      else $error("Timer clock does not follow pin 4");

   AST_CLKOUT_DRIVEN:
      assert property ((cycle_clock_out_on && $stable(osc_mode)) |=> pin_drive.oe[6])
      else $error("Cycle clock not driven on pin 6");

   AST_PIN6_GPIO_ONLY:
      assert property ((!avail[6] && !cycle_clock_out_on) [*2] |-> !pin_drive.oe[6])
      else $error("Pin 6 driven as port pin in an oscillator mode");

   AST_PIN7_EXT_OFF:
      assert property ((!avail[7]) [*2] |-> !pin_drive.oe[7])
      else $error("Pin 7 driven while oscillator owns it");

   AST_DIR_RESET:
      assert property ($fell(sys_rst) |-> dir_r == 8'hff)
      else $error("Direction bits not all input after reset");

   sequence s_cycle_clock_out_run;
      cycle_clock_out_on [*5];
   endsequence

   AST_LATCH_WRITE:
      assert property ((reg_wr.en && (reg_wr.addr == gppa_pkg::OFS_OUT_LATCH)) |=>
                       lat_r == $past(reg_wr.data[7:0]))
      else $error("Write to latch register missed the latch");

   AST_LEVELS_READ_PINS:
      assert property ((s_rd_levels ##0 (avail[2] && !an_pins_nxt[2])) |=>
                       hrdata[2] == $past(pin_sync[2]))
      else $error("Pin-level read does not return the synchronised pin");

   AST_SELECT_ALL_DIGITAL:
      assert property ((cfg_r[3:0] == 4'hf) |=> analog_pin_enable == 6'h00)
      else $error("Select value 15 left a pin analog");

   AST_SELECT_ALL_ANALOG:
      assert property ((cfg_r[3:0] == 4'h0) |=> analog_pin_enable == 6'h2f)
      else $error("Select value 0 did not make pins 0-3 and 5 analog");

   // Five steady cycles, so a mode change never trips the rate check
   AST_CLKOUT_RATE:
      assert property (s_cycle_clock_out_run |-> pin_drive.out[6] != $past(pin_drive.out[6], 2))
      else $error("Cycle clock on pin 6 is not a quarter of the clock rate");

   AST_SYNC_TWO_STAGE:
      assert property ((!$past(sys_rst) && !$past(sys_rst, 2)) |->
                       pin_sync == $past(pin_in, 2))
      else $error("Pin levels do not pass exactly two synchroniser stages");

endmodule // gppa_port_a

/* File: rtl/gppa_sync.sv */
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module gppa_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q_r
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end
endmodule // gppa_sync

/* File: tb/gppa_pin_model.sv */
// External circuitry model seen by the port A pins
`timescale 1ns/1ps
module gppa_pin_model (
   // Clock
   input wire logic ref_clk,
   // Device side
   input gppa_pkg::gppa_pin_drive_type pin_drive,
   output logic [7:0] pin_lvl,
   // Bench side
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en
);
   logic [7:0] last_r;

   always_ff @(posedge ref_clk) begin
      last_r <= pin_lvl;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Device driver wins; pin 4 has a pull-up for its open drain
   // Other floating lines wander so a stale level never reads as valid
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_drive.oe[i]) begin
            pin_lvl[i] = pin_drive.out[i];
         end else if (ext_en[i]) begin
            pin_lvl[i] = ext_val[i];
         end else begin
            pin_lvl[i] = (i == 4) ? 1'b1 : ~last_r[i];
         end
      end
   end
endmodule // gppa_pin_model

/* File: tb/testbench.sv */
// Self-checking bench of the port A block
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
   end \
end
module testbench;
   typedef struct {
      logic [7:0] a;
      logic [31:0] w;
      logic [7:0] ra;
      logic [31:0] exp;
   } gppa_tb_row_type;

   logic ref_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, timer_zero_ext_clock;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, vref_config;
   logic [2:0] hsize;
   logic [7:0] pin_in, ext_val, ext_en, s;
   logic [5:0] analog_pin_enable, an;
   logic a6, a7, ck, ok;
   gppa_pkg::gppa_osc_mode_type osc_mode;
   gppa_pkg::gppa_pin_drive_type pin_drive;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc_cnt = 0;
   gppa_tb_row_type rows[6] = '{
      '{8'h0c, 32'hff, 8'h0c, 32'h3f},
      '{8'h0c, 32'h0f, 8'h0c, 32'h0f},
      '{8'h04, 32'h5a, 8'h04, 32'h5a},
      '{8'h00, 32'h3c, 8'h04, 32'h3c},
      '{8'h08, 32'hffff_ff0f, 8'h08, 32'h0f},
      '{8'h10, 32'hff, 8'h10, 32'h0}};

   assign hready = hreadyout;

   gppa_port_a gppa_port_a_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .osc_mode(osc_mode), .pin_in(pin_in), .pin_drive(pin_drive),
      .timer_zero_ext_clock(timer_zero_ext_clock), .analog_pin_enable(analog_pin_enable),
      .vref_config(vref_config));

   gppa_pin_model gppa_pin_model_i (.ref_clk(ref_clk), .pin_drive(pin_drive),
      .pin_lvl(pin_in), .ext_val(ext_val), .ext_en(ext_en));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus tasks: one single word transfer, waits on hready each phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rq);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      rq = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dq;
      bus(1'b1, a, d, dq);
   endtask

   task automatic end_of_test();
      $display("Checks done %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Reset, then defaults; pins 6 and 7 free in the dual io mode
   task automatic rst_chk();
      sys_rst <= 1'b1;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      bus(1'b0, 8'h08, 32'h0, q);
      `CHK(q, 32'hff)
      bus(1'b0, 8'h04, 32'h0, q);
      `CHK(q, 32'h0)
      bus(1'b0, 8'h0c, 32'h0, q);
      `CHK(q, 32'h0)
      bus(1'b0, 8'h00, 32'h0, q);
      `CHK(q, 32'hd0)
      `CHK(analog_pin_enable, 6'h2f)
      `CHK(pin_drive.oe, 8'h00)
      `CHK({hreadyout, hresp}, 2'b10)
   endtask

   always @(posedge ref_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         error_cnt++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      osc_mode = gppa_pkg::internal_osc_dual_io_mode;
      ext_val = 8'hff;
      ext_en = 8'hef;
      rst_chk();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         bus(1'b0, rows[i].ra, 32'h0, q);
         `CHK(q, rows[i].exp)
      end
      // Latch 3c, direction 0f: pins 7..4 outputs, pin 4 latch high
      @(posedge ref_clk);
      #1;
      `CHK(pin_drive.oe, 8'he0)
      `CHK(pin_drive.out & pin_drive.oe, 8'h20)
      wr(8'h04, 32'h2c);
      @(posedge ref_clk);
      #1;
      `CHK(pin_drive.oe, 8'hf0)
      `CHK(pin_drive.out & pin_drive.oe, 8'h20)
      // All analog, pin 1 made an output: it must still drive
      wr(8'h0c, 32'h0);
      wr(8'h08, 32'h0d);
      @(posedge ref_clk);
      #1;
      `CHK(pin_drive.oe, 8'hf2)
      wr(8'h08, 32'hff);
      wr(8'h0c, 32'h0f);
      // Pin 4 reaches the timer three edges later
      ext_en <= 8'hff;
      repeat (4) @(posedge ref_clk);
      ext_val <= 8'hef;
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(timer_zero_ext_clock, 1'b1)
      @(posedge ref_clk);
      #1;
      `CHK(timer_zero_ext_clock, 1'b0)
      ext_val <= 8'hff;
      wr(8'h04, 32'h0);
      wr(8'h08, 32'hef);
      repeat (5) @(posedge ref_clk);
      #1;
      `CHK(timer_zero_ext_clock, 1'b0)
      wr(8'h08, 32'hff);
      // Pin reads see levels from two edges back only; pin 4 was still pulled low
      ext_val <= 8'h00;
      bus(1'b0, 8'h00, 32'h0, q);
      `CHK(q, 32'hef)
      bus(1'b0, 8'h00, 32'h0, q);
      `CHK(q, 32'h00)
      ext_val <= 8'hff;
      wr(8'h0c, 32'h2f);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(vref_config, 2'h2)
      for (int sel = 0; sel < 16; sel++) begin
         wr(8'h0c, 32'(sel));
         repeat (3) @(posedge ref_clk);
         for (int k = 0; k < 4; k++) an[k] = (sel < 15 - k);
         an[4] = 1'b0;
         an[5] = (sel < 11);
         `CHK(analog_pin_enable, an)
         bus(1'b0, 8'h00, 32'h0, q);
         `CHK(q, {24'h0, 8'hff & ~{2'b00, an}})
      end
      wr(8'h0c, 32'h0f);
      wr(8'h04, 32'hff);
      wr(8'h08, 32'h00);
      for (int i = 0; i < 10; i++) begin
         osc_mode <= gppa_pkg::gppa_osc_mode_type'(i);
         repeat (3) @(posedge ref_clk);
         a6 = osc_mode inside {gppa_pkg::rc_osc_with_io_mode,
            gppa_pkg::internal_osc_dual_io_mode, gppa_pkg::ext_clock_with_io_mode};
         a7 = osc_mode inside {gppa_pkg::internal_osc_dual_io_mode,
            gppa_pkg::internal_osc_clock_out_mode};
         ck = !a6 && !(osc_mode inside {gppa_pkg::resistor_capacitor_osc_mode,
            gppa_pkg::internal_osc_clock_out_mode, gppa_pkg::ext_clock_mode});
         bus(1'b0, 8'h04, 32'h0, q);
         `CHK(q, {24'h0, a7, a6, 6'h3f})
         bus(1'b0, 8'h00, 32'h0, q);
         `CHK(q, {24'h0, a7, a6, 6'h3f})
         `CHK(pin_drive.oe[7:6], {a7, a6 | ck})
         for (int j = 0; j < 8; j++) begin
            @(posedge ref_clk);
            #1;
            s[j] = pin_drive.out[6];
         end
         ok = 1'b1;
         for (int j = 0; j < 6; j++) if (s[j + 2] === s[j]) ok = 1'b0;
         if (ck) begin
            `CHK(ok, 1'b1)
         end else if (a6) begin
            `CHK(s, 8'hff)
         end else begin
            `CHK(s, 8'h00)
         end
      end
      // Pin 6 owned, pin 7 not: its direction bit reads zero
      wr(8'h08, 32'hff);
      bus(1'b0, 8'h08, 32'h0, q);
      `CHK(q, 32'hbf)
      osc_mode <= gppa_pkg::internal_osc_dual_io_mode;
      ext_en <= 8'hef;
      rst_chk();
      end_of_test();
   end
endmodule // testbench
